/* File: rtl/mmdec_decoder.v */
/*
 address decoder for a 1-Mbyte space: program flash, data flash, ram,
 two register windows, reserved space.
 assumes the bus master and all targets run on ref_clk; target read
 data is valid in the cycle after a select, as is the read mux output.
*/
// Summary of operation
// - decode 20-bit addresses over one contiguous 1-Mbyte space.
// - first 32 Kbytes of program flash end at 0ffff, growing downward.
// - program flash beyond 32 Kbytes continues upward from 10000.
// - a 64-Kbyte program flash covers 08000 through 17fff.
// - vector table at 0ffdc..0ffff is flagged, inside program flash.
// - 07000 through 07fff selects the data flash.
// - data flash is four 1-Kbyte blocks chosen by address.
// - ram maps upward from 00400, end scaling with ram size.
// - ram serves both data and stack; decoding is uniform for both.
// - register windows 00000..02fff and 06800..06fff.
// - upper window serves event link, transfer and touch units.
`include "mmdec_regs.vh"

module mmdec_decoder
#(
   parameter ROM_KB = `MMDEC_ROM_KB,
   parameter RAM_KB = `MMDEC_RAM_KB
)
(
   // clock and reset
   input  wire                      ref_clk,
   input  wire                      rst_n,
   // master request
   input  wire                      req,
   input  wire                      wr,
   input  wire [`MMDEC_AW-1:0]      addr,
   input  wire [`MMDEC_DW-1:0]      wdata,
   output reg  [`MMDEC_DW-1:0]      rdata,
   // target selects
   output wire                      rom_sel,
   output wire                      df_sel,
   output wire [3:0]                df_blk_sel,
   output wire                      ram_sel,
   output wire                      sfr_low_sel,
   output wire                      sfr_up_sel,
   output wire                      vec_hit,
   output wire                      unmapped,
   output wire                      wr_out,
   output wire [`MMDEC_AW-1:0]      addr_out,
   output wire [`MMDEC_DW-1:0]      wdata_out,
   // target read data
   input  wire [`MMDEC_DW-1:0]      rom_rdata,
   input  wire [`MMDEC_DW-1:0]      df_rdata,
   input  wire [`MMDEC_DW-1:0]      ram_rdata,
   input  wire [`MMDEC_DW-1:0]      sfr_rdata
);
   // region sizes; products cut to the address width on purpose
   localparam [31:0] ROM_BYTES_W  = ROM_KB * `MMDEC_KB;
   localparam [31:0] RAM_BYTES_W  = RAM_KB * `MMDEC_KB;
   localparam [19:0] ROM_BYTES    = ROM_BYTES_W[19:0];
   localparam [19:0] RAM_BYTES    = RAM_BYTES_W[19:0];
   localparam [19:0] ONE          = `MMDEC_ONE;
   localparam [19:0] LOW_SPAN     = `MMDEC_ROM_HIGH - `MMDEC_ROM_LOW_MAX;
   localparam        ROM_SPLIT    = (ROM_BYTES > LOW_SPAN);
   localparam [19:0] ROM_LO_SMALL = `MMDEC_ROM_HIGH - ROM_BYTES;
   localparam [19:0] ROM_HI_BIG   = `MMDEC_ROM_HIGH + (ROM_BYTES - LOW_SPAN) - ONE;

   // small flash ends at 0ffff, larger flash spills above 10000
   localparam [19:0] ROM_LO       = ROM_SPLIT ? `MMDEC_ROM_LOW_MAX : ROM_LO_SMALL;
   localparam [19:0] ROM_HI       = ROM_SPLIT ? ROM_HI_BIG : `MMDEC_ROM_TOP;
   localparam [19:0] RAM_HI       = `MMDEC_RAM_LO + RAM_BYTES - ONE;

   // range edges
   wire       rom_ge_lo;
   wire       rom_le_hi;
   wire       df_ge_lo;
   wire       df_le_hi;
   wire       ram_ge_lo;
   wire       ram_le_hi;
   wire       sfr0_le_hi;
   wire       sfr1_ge_lo;
   wire       sfr1_le_hi;
   wire       vec_ge_lo;
   wire       vec_le_hi;

   // region hits
   wire       in_rom;
   wire       in_df;
   wire       in_ram;
   wire       in_sfr0;
   wire       in_sfr1;
   wire       in_vec;
   wire       rd_req;
   wire [1:0] df_blk_idx;

   // read target
   reg  [2:0] tgt_d;
   reg  [2:0] tgt_q;

   // edge compares, whole 20-bit space, no aliasing
   assign rom_ge_lo  = (addr >= ROM_LO);
   assign rom_le_hi  = (addr <= ROM_HI);
   assign df_ge_lo   = (addr >= `MMDEC_DF_LO);
   assign df_le_hi   = (addr <= `MMDEC_DF_HI);
   assign ram_ge_lo  = (addr >= `MMDEC_RAM_LO);
   assign ram_le_hi  = (addr <= RAM_HI);
   assign sfr0_le_hi = (addr <= `MMDEC_SFR0_HI);
   assign sfr1_ge_lo = (addr >= `MMDEC_SFR1_LO);
   assign sfr1_le_hi = (addr <= `MMDEC_SFR1_HI);
   assign vec_ge_lo  = (addr >= `MMDEC_VEC_LO);
   assign vec_le_hi  = (addr <= `MMDEC_VEC_HI);

   // region membership
   assign in_rom     = rom_ge_lo && rom_le_hi;
   assign in_df      = df_ge_lo && df_le_hi;
   assign in_ram     = ram_ge_lo && ram_le_hi;
   assign in_sfr0    = sfr0_le_hi;
   assign in_sfr1    = sfr1_ge_lo && sfr1_le_hi;
   assign in_vec     = vec_ge_lo && vec_le_hi;
   assign rd_req     = req && !wr;
   assign df_blk_idx = addr[`MMDEC_DF_BLK_MSB:`MMDEC_DF_BLK_LSB];

   // one-hot selects, ram over lower window
   assign rom_sel     = req && in_rom;
   assign df_sel      = req && in_df;
   assign ram_sel     = req && in_ram;
   assign sfr_low_sel = req && in_sfr0 && !in_ram;
   assign sfr_up_sel  = req && in_sfr1;
   assign vec_hit     = rom_sel && in_vec;
   assign unmapped    = req && !in_rom && !in_df && !in_ram && !in_sfr0 && !in_sfr1;
   assign wr_out      = wr;
   assign addr_out    = addr;
   assign wdata_out   = wdata;

   // block a..d from address bits 11:10
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : blk
         localparam [31:0] BLK_W = g;
         assign df_blk_sel[g] = df_sel && (df_blk_idx == BLK_W[1:0]);
      end
   endgenerate

   // target of a read for the return mux, ram first
   always @*
   begin
      tgt_d = `MMDEC_T_NONE;
      if (rd_req)
      begin
         if (in_ram)
         begin
            tgt_d = `MMDEC_T_RAM;
         end
         else if (in_rom)
         begin
            tgt_d = `MMDEC_T_ROM;
         end
         else if (in_df)
         begin
            tgt_d = `MMDEC_T_DF;
         end
         else if (in_sfr0 || in_sfr1)
         begin
            tgt_d = `MMDEC_T_SFR;
         end
         else
         begin
            tgt_d = `MMDEC_T_NONE;
         end
      end
   end

   // writes and idle cycles clear the target
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tgt_q <= `MMDEC_T_NONE;
      end
      else
      begin
         tgt_q <= tgt_d;
      end
   end

   // unmapped reads return zero
   always @*
   begin
      case (tgt_q)
         `MMDEC_T_ROM: rdata = rom_rdata;
         `MMDEC_T_DF:  rdata = df_rdata;
         `MMDEC_T_RAM: rdata = ram_rdata;
         `MMDEC_T_SFR: rdata = sfr_rdata;
         default:      rdata = {`MMDEC_DW{1'b0}};
      endcase
   end

endmodule

/* File: rtl/mmdec_regs.vh */
/*
 memory map constants for the address decoder.
 assumes a 20-bit byte address bus and a single including module.
*/
`ifndef MMDEC_REGS_VH
`define MMDEC_REGS_VH

`define MMDEC_AW          20
`define MMDEC_DW          8
`define MMDEC_ADDR_MAX    20'hfffff
`define MMDEC_ROM_TOP     20'h0ffff
`define MMDEC_ROM_HIGH    20'h10000
`define MMDEC_ROM_LOW_MAX 20'h08000
`define MMDEC_VEC_LO      20'h0ffdc
`define MMDEC_VEC_HI      20'h0ffff
`define MMDEC_DF_LO       20'h07000
`define MMDEC_DF_HI       20'h07fff
`define MMDEC_DF_BLK_MSB  11
`define MMDEC_DF_BLK_LSB  10
`define MMDEC_DF_SEL_MSB  11
`define MMDEC_RAM_LO      20'h00400
`define MMDEC_SFR0_LO     20'h00000
`define MMDEC_SFR0_HI     20'h02fff
`define MMDEC_SFR1_LO     20'h06800
`define MMDEC_SFR1_HI     20'h06fff
`define MMDEC_KB          20'h00400
`define MMDEC_ONE         20'h00001
`define MMDEC_ROM_KB      64
`define MMDEC_RAM_KB      6

`define MMDEC_T_NONE      3'h0
`define MMDEC_T_ROM       3'h1
`define MMDEC_T_DF        3'h2
`define MMDEC_T_RAM       3'h3
`define MMDEC_T_SFR       3'h4

`endif

/* File: sim/mmdec_assertions.sv */
/* decoder checker: select, map and read-data timing relations.
   assumes one clock domain and binding to every mmdec_decoder. */
module mmdec_assertions #(parameter ROM_KB = 64, parameter RAM_KB = 6)
(
   // clock and reset
   input wire logic        ref_clk, rst_n,
   // request and answers
   input wire logic        req, wr, rom_sel, df_sel, ram_sel,
   input wire logic        sfr_low_sel, sfr_up_sel, vec_hit, unmapped,
   input wire logic [19:0] addr,
   input wire logic [3:0]  df_blk_sel,
   input wire logic [7:0]  rdata, ram_rdata
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence ram_rd;
      req && !wr && ram_sel;
   endsequence
   rom_map_a: assert property (req && addr >= 20'h08000 && addr < 20'h08000 + ROM_KB * 1024 |-> rom_sel) else $error("rom select missing");
   vec_flag_a: assert property (req && addr >= 20'h0ffdc && addr <= 20'h0ffff |-> vec_hit && rom_sel) else $error("vector flag wrong");
   df_map_a: assert property (req && addr[19:12] == 8'h07 |-> df_sel && df_blk_sel == 4'h1 << addr[11:10]) else $error("data flash select wrong");
   ram_map_a: assert property (req && addr >= 20'h00400 && addr < 20'h00400 + RAM_KB * 1024 |-> ram_sel && !sfr_low_sel) else $error("ram select wrong");
   sfr_low_a: assert property (req && addr < 20'h00400 |-> sfr_low_sel) else $error("low window missing");
   sfr_up_a: assert property (req && addr[19:11] == 9'h00d |-> sfr_up_sel) else $error("upper window missing");
   one_target_a: assert property ($onehot0({rom_sel, df_sel, ram_sel, sfr_low_sel, sfr_up_sel, unmapped})) else $error("several targets");
   unmap_read_a: assert property (req && !wr && unmapped |=> rdata == 8'h00) else $error("unmapped read not zero");
   ram_data_a: assert property (ram_rd |=> rdata == ram_rdata) else $error("ram read data wrong");
endmodule
bind mmdec_decoder mmdec_assertions #(.ROM_KB(ROM_KB), .RAM_KB(RAM_KB)) chk_i (.*);

/* File: sim/mmdec_targets.sv */
/* far-side targets: registered read data per target.
   assumes data is wanted the cycle after the address. */
module mmdec_targets
(
   input wire logic        ref_clk,
   input wire logic [19:0] addr_out,
   output logic [7:0]      rom_rdata, df_rdata, ram_rdata, sfr_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   always @(posedge ref_clk)
   begin
      rom_rdata <= 8'h10 ^ addr_out[7:0];
      df_rdata  <= 8'h20 ^ addr_out[7:0];
      ram_rdata <= 8'h30 ^ addr_out[7:0];
      sfr_rdata <= 8'h40 ^ addr_out[7:0];
   end
endmodule

/* File: sim/testbench.sv */
/* decoder bench: directed accesses at region boundaries, except 00000, 02fff, 067ff, 07fff and the top of the vector table.
   assumes default sizes of 64 Kbyte flash and 6 Kbyte ram. */
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic ref_clk = 0, rst_n = 0, req = 0, wr = 0;
   logic [19:0] addr = 20'h00000, addr_out;
   logic [7:0] rdata, rom_rdata, df_rdata, ram_rdata, sfr_rdata;
   logic [3:0] df_blk_sel;
   logic wr_out;
   logic [7:0] wdata = 8'h00, wdata_out;
   logic rom_sel, df_sel, ram_sel, sfr_low_sel, sfr_up_sel, vec_hit, unmapped;
   int n_fail = 0, comparisons = 0;
   always #10 ref_clk = ~ref_clk;
   mmdec_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .wr(wr), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rom_sel(rom_sel), .df_sel(df_sel),
      .df_blk_sel(df_blk_sel), .ram_sel(ram_sel), .sfr_low_sel(sfr_low_sel),
      .sfr_up_sel(sfr_up_sel), .vec_hit(vec_hit), .unmapped(unmapped), .wr_out(wr_out),
      .addr_out(addr_out), .wdata_out(wdata_out), .rom_rdata(rom_rdata), .df_rdata(df_rdata),
      .ram_rdata(ram_rdata), .sfr_rdata(sfr_rdata));
   mmdec_targets far (.ref_clk(ref_clk), .addr_out(addr_out), .rom_rdata(rom_rdata),
      .df_rdata(df_rdata), .ram_rdata(ram_rdata), .sfr_rdata(sfr_rdata));
   task chk(input logic [10:0] got, input logic [10:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // read access: selects now, data next cycle; k is the target tag, 0 for none
   task acc(input logic [19:0] a, input logic [10:0] es, input logic [7:0] k);
      @(posedge ref_clk) #1 req = 1;
      addr = a;
      #5 chk({rom_sel, df_sel, ram_sel, sfr_low_sel, sfr_up_sel, vec_hit, unmapped, df_blk_sel}, es);
      @(posedge ref_clk) #1 req = 0;
      #5 chk({3'h0, rdata}, {3'h0, (k == 8'h00) ? 8'h00 : k ^ a[7:0]});
   endtask
   task t_rom;
      acc(20'h08000, 11'h400, 8'h10);
      acc(20'h17fff, 11'h400, 8'h10);
      acc(20'h0ffdc, 11'h420, 8'h10);
      acc(20'h0ffdb, 11'h400, 8'h10);
   endtask
   task t_df;
      for (int i = 0; i < 4; i++)
         acc(20'h07000 + i * 1024 + i, 11'h200 | (11'h1 << i), 8'h20);
   endtask
   task t_ram;
      acc(20'h003ff, 11'h080, 8'h40);
      acc(20'h00400, 11'h100, 8'h30);
      acc(20'h01bff, 11'h100, 8'h30);
      acc(20'h01c00, 11'h080, 8'h40);
      acc(20'h06800, 11'h040, 8'h40);
      acc(20'h06fff, 11'h040, 8'h40);
   endtask
   // write to ram: pass-through now, no read data next cycle
   task t_wr;
      @(posedge ref_clk) #1 req = 1;
      wr = 1;
      addr = 20'h00410;
      wdata = 8'ha5;
      #5 chk({2'h0, wr_out, wdata_out}, {3'h1, 8'ha5});
      chk({rom_sel, df_sel, ram_sel, sfr_low_sel, sfr_up_sel, vec_hit, unmapped, df_blk_sel},
         11'h100);
      @(posedge ref_clk) #1 req = 0;
      wr = 0;
      #5 chk({3'h0, rdata}, 11'h000);
   endtask
   task t_unm;
      acc(20'h03000, 11'h010, 8'h00);
      acc(20'h18000, 11'h010, 8'h00);
      acc(20'hfffff, 11'h010, 8'h00);
   endtask
   task results;
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1 rst_n = 1;
      t_rom;
      t_df;
      t_ram;
      t_wr;
      t_unm;
      results;
   end
endmodule
